// ---- hdl/icc_pkg.sv ----
`default_nettype none
// ----------------------------------------------------------------
// Register map, field positions and rate table
// ----------------------------------------------------------------
package icc_pkg;

  localparam logic [7:0] ICC_ADR_CTRL = 8'h00;
  localparam logic [7:0] ICC_ADR_MODE = 8'h04;
  localparam logic [7:0] ICC_ADR_DATA = 8'h08;
  localparam logic [7:0] ICC_ADR_SCTL = 8'h0C;
  localparam logic [7:0] ICC_ADR_STAT = 8'h10;
  localparam logic [7:0] ICC_ADR_MASK = 8'h14;

  localparam int ICC_B_ON = 7;
  localparam int ICC_B_IRQEN = 6;
  localparam int ICC_B_MS = 5;
  localparam int ICC_B_TX = 4;
  localparam int ICC_B_FLAG = 1;
  localparam int ICC_B_EXT = 0;
  localparam int ICC_CKS_HI = 5;
  localparam int ICC_CKS_LO = 3;

  localparam int ICC_ST_NINTH = 0;
  localparam int ICC_ST_ARB = 1;
  localparam int ICC_ST_HW = 2;
  localparam int ICC_ST_W = 3;

  localparam logic [7:0] ICC_REG_RST = 8'h00;
  localparam logic [3:0] ICC_CNT_ZERO = 4'h0;
  localparam logic [3:0] ICC_NINTH = 4'h8;
  localparam logic [3:0] ICC_FRAME_CLKS = 4'h9;

  typedef enum logic [1:0] {
    ICC_SLV_RX,
    ICC_SLV_TX,
    ICC_MST_RX,
    ICC_MST_TX
  } icc_mode_type;

  typedef enum logic {
    ICC_FR_IDLE,
    ICC_FR_RUN
  } icc_frame_type;

  // System clocks per serial clock period.
  function automatic logic [8:0] icc_divisor(input logic ext,
                                             input logic [2:0] sel);
    logic [8:0] d;
    d = 9'h01C;
    case ({ext, sel})
      4'h0: d = 9'h01C;
      4'h1: d = 9'h028;
      4'h2: d = 9'h030;
      4'h3: d = 9'h040;
      4'h4: d = 9'h050;
      4'h5: d = 9'h064;
      4'h6: d = 9'h070;
      4'h7: d = 9'h080;
      4'h8: d = 9'h038;
      4'h9: d = 9'h050;
      4'hA: d = 9'h060;
      4'hB: d = 9'h080;
      4'hC: d = 9'h0A0;
      4'hD: d = 9'h0C8;
      4'hE: d = 9'h0E0;
      4'hF: d = 9'h100;
      default: d = 9'h01C;
    endcase
    return d;
  endfunction

endpackage
`default_nettype wire

// ---- hdl/icc_rate_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module icc_rate_gen (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic ext_i,
  input wire logic [2:0] sel_i,
  output logic scl_low_o,
  output logic rise_o,
  output logic fall_o
);
  import icc_pkg::*;

  logic [8:0] div;
  logic [7:0] div_m1, half, cnt, next_cnt;
  logic next_low, next_rise, next_fall;
  logic [8:0] gap;
  logic seen;
  logic [8:0] div_q;

  assign div = icc_divisor(ext_i, sel_i);
  assign div_m1 = div[7:0] - 8'h01;
  assign half = div[8:1];

  // The low phase takes half the period, the high phase the rest.
  always_comb begin
    next_cnt = 8'h00;
    next_low = 1'h0;
    next_rise = 1'h0;
    next_fall = 1'h0;
    if (run_i) begin
      next_cnt = (cnt == div_m1) ? 8'h00 : cnt + 8'h01;
      next_low = next_cnt < half;
      next_rise = next_cnt == half;
      next_fall = cnt == div_m1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= 8'h00;
      scl_low_o <= 1'h0;
      rise_o <= 1'h0;
      fall_o <= 1'h0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      scl_low_o <= next_low;
      rise_o <= next_rise;
      fall_o <= next_fall;
    end
  end

  // Cycles between rising edges, for checking only.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gap <= 9'h000;
      seen <= 1'h0;
      div_q <= 9'h000;
    end else if (ce_i) begin
      div_q <= div;
      gap <= rise_o ? 9'h001 : gap + 9'h001;
      if (!run_i || div != div_q)
        seen <= 1'h0;
      else if (rise_o)
        seen <= 1'h1;
    end
  end

  property p_period;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && rise_o && seen && run_i && div == div_q) |-> gap == div;
  endproperty
  a_period: assert property (p_period)
    else $error("serial clock period differs from divisor");

endmodule
`default_nettype wire

// ---- hdl/icc_mode_ctl.sv ----
`timescale 1ns/10ps
`default_nettype none
module icc_mode_ctl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic ms_i,
  input wire logic tx_i,
  input wire logic rd_i,
  input wire logic arb_lost_i,
  input wire logic addr_rw_i,
  input wire logic rw_bit_i,
  input wire logic busy_i,
  output logic master_o,
  output logic tx_o,
  output logic hw_chg_o
);
  import icc_pkg::*;

  logic locked, pend, pend_tx;
  logic next_master, next_tx, next_locked, next_pend, next_pend_tx;
  logic chg;

  always_comb begin
    next_master = master_o;
    next_tx = tx_o;
    next_locked = locked;
    next_pend = pend;
    next_pend_tx = pend_tx;
    chg = 1'h0;
    if (pend && !busy_i) begin
      next_tx = pend_tx;
      next_pend = 1'h0;
    end
    // A bit changed by hardware stays put until software has read it.
    if (wr_i && !locked) begin
      next_master = ms_i;
      if (busy_i && tx_i != tx_o) begin
        next_pend = 1'h1;
        next_pend_tx = tx_i;
      end else begin
        next_tx = tx_i;
        next_pend = 1'h0;
      end
    end
    if (rd_i)
      next_locked = 1'h0;
    if (arb_lost_i && master_o) begin
      next_master = 1'h0;
      next_tx = 1'h0;
      next_pend = 1'h0;
      chg = 1'h1;
    end else if (addr_rw_i && !master_o && !tx_o) begin
      next_tx = rw_bit_i;
      chg = rw_bit_i;
    end
    if (chg)
      next_locked = 1'h1;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      master_o <= 1'h0;
      tx_o <= 1'h0;
      locked <= 1'h0;
      pend <= 1'h0;
      pend_tx <= 1'h0;
      hw_chg_o <= 1'h0;
    end else if (ce_i) begin
      master_o <= next_master;
      tx_o <= next_tx;
      locked <= next_locked;
      pend <= next_pend;
      pend_tx <= next_pend_tx;
      hw_chg_o <= chg;
    end
  end

  property p_arb;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && arb_lost_i && master_o) |=> (!master_o && !tx_o && hw_chg_o);
  endproperty
  a_arb: assert property (p_arb)
    else $error("mode bits not cleared on lost arbitration");

  property p_auto;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && addr_rw_i && !arb_lost_i && !master_o && !tx_o)
      |=> tx_o == $past(rw_bit_i);
  endproperty
  a_auto: assert property (p_auto)
    else $error("transmit bit does not follow first frame");

  property p_lock;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && locked && wr_i && !rd_i && !arb_lost_i)
      |=> master_o == $past(master_o);
  endproperty
  a_lock: assert property (p_lock)
    else $error("mode rewrite accepted before read");

  property p_defer;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && busy_i && wr_i && !locked && tx_i != tx_o
      && !arb_lost_i && !addr_rw_i) |=> tx_o == $past(tx_o);
  endproperty
  a_defer: assert property (p_defer)
    else $error("transmit bit changed inside a frame");

endmodule
`default_nettype wire

// ---- hdl/icc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Without range extension, select codes give divisors 28 to 128.
// - With range extension, select codes give divisors 56 to 256.
// - Extension from serial control bit 0, select from mode bits 5..3.
// - Enabled interface is joined to the pins and may drive them.
// - Disabled interface halts, neither drives nor samples the pins.
// - Mode and data reachable when enabled, slave addresses otherwise.
// - Interrupt request raised from the flag only while allowed.
// - Master and transmit bits decode into four operating modes.
// - Lost arbitration as master clears master and transmit bits.
// - In slave receive the first frame's direction bit sets transmit.
// - Bits changed by hardware accept rewrites only after a read.
// - Transmit change during a frame waits until frame and ack end.
// - Master frame sets the interrupt flag at the ninth rising clock.
module icc_top (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ_O,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic SCL_IN_O,
  output logic SDA_IN_O,
  input wire logic SDA_LOW_I,
  input wire logic FRAME_START_I,
  input wire logic SLV_BUSY_I,
  input wire logic ARB_LOST_I,
  input wire logic ADDR_RW_I,
  input wire logic RW_BIT_I,
  output var icc_pkg::icc_mode_type MODE_O
);
  import icc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic iface_on, irq_allow, irq_flag, ext;
  logic next_iface_on, next_irq_allow, next_irq_flag, next_ext;
  logic [7:0] mode_reg, data_reg, sa_reg, sax_reg;
  logic [7:0] next_mode_reg, next_data_reg, next_sa_reg, next_sax_reg;
  logic [ICC_ST_W-1:0] stat, mask, next_stat, next_mask, ev;
  logic next_ack;
  logic [31:0] next_rdata;
  logic req, take, wr, wr_ctl, rd_ctl;
  logic [7:0] word_adr, ctrl_byte, d;
  logic master_sel, tx_sel, hw_chg, busy;
  logic scl_low, rise, fall, ninth, frame_end, arb_ev;
  logic [2:0] clk_sel;
  icc_frame_type fr, next_fr;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic next_irq, next_scl_oe, next_sda_oe, next_scl_in, next_sda_in;
  icc_mode_type next_mode;

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Answer one cycle after the request; the write lands at the edge
  // where the master sees the acknowledge.
  assign req = WB_CYC_I && WB_STB_I;
  assign take = req && WB_ACK_O;
  assign wr = take && WB_WE_I && WB_SEL_I[0];
  assign word_adr = {WB_ADR_I[7:2], 2'h0};
  assign d = WB_DAT_I[7:0];
  assign wr_ctl = wr && word_adr == ICC_ADR_CTRL;
  assign rd_ctl = take && !WB_WE_I && word_adr == ICC_ADR_CTRL;
  assign ctrl_byte = {iface_on, irq_allow, master_sel, tx_sel,
                      2'h0, irq_flag, 1'h0};

  // Hardware events; each one sets a sticky status bit.
  assign arb_ev = ARB_LOST_I && master_sel && iface_on;
  assign ev = {hw_chg, arb_ev, ninth};

  always_comb begin
    next_ack = req && !WB_ACK_O;
    next_rdata = 32'h0000_0000;
    next_iface_on = iface_on;
    next_irq_allow = irq_allow;
    next_irq_flag = irq_flag;
    next_ext = ext;
    next_mode_reg = mode_reg;
    next_data_reg = data_reg;
    next_sa_reg = sa_reg;
    next_sax_reg = sax_reg;
    next_stat = stat;
    next_mask = mask;
    if (req && !WB_ACK_O && !WB_WE_I) begin
      case (word_adr)
        ICC_ADR_CTRL: next_rdata[7:0] = ctrl_byte;
        ICC_ADR_MODE: next_rdata[7:0] = iface_on ? mode_reg : sa_reg;
        ICC_ADR_DATA: next_rdata[7:0] = iface_on ? data_reg : sax_reg;
        ICC_ADR_SCTL: next_rdata[ICC_B_EXT] = ext;
        ICC_ADR_STAT: next_rdata[ICC_ST_W-1:0] = stat;
        ICC_ADR_MASK: next_rdata[ICC_ST_W-1:0] = mask;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (word_adr)
        ICC_ADR_CTRL: begin
          next_iface_on = d[ICC_B_ON];
          next_irq_allow = d[ICC_B_IRQEN];
          // The flag is cleared by writing zero; a one leaves it.
          if (!d[ICC_B_FLAG])
            next_irq_flag = 1'h0;
        end
        ICC_ADR_MODE: begin
          if (iface_on)
            next_mode_reg = d;
          else
            next_sa_reg = d;
        end
        ICC_ADR_DATA: begin
          if (iface_on)
            next_data_reg = d;
          else
            next_sax_reg = d;
        end
        ICC_ADR_SCTL: next_ext = d[ICC_B_EXT];
        ICC_ADR_STAT: next_stat = stat & ~WB_DAT_I[ICC_ST_W-1:0];
        ICC_ADR_MASK: next_mask = WB_DAT_I[ICC_ST_W-1:0];
        default: next_stat = stat;
      endcase
    end
    // Events win over a clear in the same cycle.
    next_stat = next_stat | ev;
    if (ninth)
      next_irq_flag = 1'h1;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      WB_ACK_O <= 1'h0;
      WB_DAT_O <= 32'h0000_0000;
      iface_on <= 1'h0;
      irq_allow <= 1'h0;
      irq_flag <= 1'h0;
      ext <= 1'h0;
      mode_reg <= ICC_REG_RST;
      data_reg <= ICC_REG_RST;
      sa_reg <= ICC_REG_RST;
      sax_reg <= ICC_REG_RST;
      stat <= '0;
      mask <= '0;
    end else if (CE_I) begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_rdata;
      iface_on <= next_iface_on;
      irq_allow <= next_irq_allow;
      irq_flag <= next_irq_flag;
      ext <= next_ext;
      mode_reg <= next_mode_reg;
      data_reg <= next_data_reg;
      sa_reg <= next_sa_reg;
      sax_reg <= next_sax_reg;
      stat <= next_stat;
      mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // Mode bits and serial clock
  // ----------------------------------------------------------------
  // Slave events are ignored while the interface is switched off.
  icc_mode_ctl u_mode (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .wr_i(wr_ctl),
    .ms_i(d[ICC_B_MS]),
    .tx_i(d[ICC_B_TX]),
    .rd_i(rd_ctl),
    .arb_lost_i(arb_ev),
    .addr_rw_i(ADDR_RW_I && iface_on),
    .rw_bit_i(RW_BIT_I),
    .busy_i(busy),
    .master_o(master_sel),
    .tx_o(tx_sel),
    .hw_chg_o(hw_chg)
  );

  assign clk_sel = mode_reg[ICC_CKS_HI:ICC_CKS_LO];

  icc_rate_gen u_rate (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .run_i(fr == ICC_FR_RUN),
    .ext_i(ext),
    .sel_i(clk_sel),
    .scl_low_o(scl_low),
    .rise_o(rise),
    .fall_o(fall)
  );

  // ----------------------------------------------------------------
  // Master frame sequencing
  // ----------------------------------------------------------------
  // A frame is eight data clocks and one acknowledge clock; it ends
  // on the falling edge after the ninth clock, so the acknowledge
  // bit counts as part of the frame for deferred mode changes.
  assign ninth = (fr == ICC_FR_RUN) && rise && bit_cnt == ICC_NINTH;
  assign frame_end = fall && bit_cnt == ICC_FRAME_CLKS;
  assign busy = (fr == ICC_FR_RUN) || SLV_BUSY_I;

  always_comb begin
    next_fr = fr;
    next_bit_cnt = bit_cnt;
    unique case (fr)
      ICC_FR_IDLE: begin
        if (FRAME_START_I && iface_on && master_sel) begin
          next_fr = ICC_FR_RUN;
          next_bit_cnt = ICC_CNT_ZERO;
        end
      end
      ICC_FR_RUN: begin
        if (rise)
          next_bit_cnt = bit_cnt + 4'h1;
        if (frame_end || !iface_on || arb_ev)
          next_fr = ICC_FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      fr <= ICC_FR_IDLE;
      bit_cnt <= ICC_CNT_ZERO;
    end else if (CE_I) begin
      fr <= next_fr;
      bit_cnt <= next_bit_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Pins, interrupt and mode outputs
  // ----------------------------------------------------------------
  // Both lines are open drain: only a low level is ever driven.
  always_comb begin
    next_scl_oe = iface_on && fr == ICC_FR_RUN && scl_low;
    next_sda_oe = iface_on && SDA_LOW_I;
    next_scl_in = iface_on ? SCL_I : 1'h1;
    next_sda_in = iface_on ? SDA_I : 1'h1;
    next_irq = (irq_flag && irq_allow) || |(stat & mask);
    next_mode = icc_mode_type'({master_sel, tx_sel});
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      SCL_O <= 1'h0;
      SDA_O <= 1'h0;
      SCL_OE_O <= 1'h0;
      SDA_OE_O <= 1'h0;
      SCL_IN_O <= 1'h1;
      SDA_IN_O <= 1'h1;
      IRQ_O <= 1'h0;
      MODE_O <= ICC_SLV_RX;
    end else if (CE_I) begin
      SCL_O <= 1'h0;
      SDA_O <= 1'h0;
      SCL_OE_O <= next_scl_oe;
      SDA_OE_O <= next_sda_oe;
      SCL_IN_O <= next_scl_in;
      SDA_IN_O <= next_sda_in;
      IRQ_O <= next_irq;
      MODE_O <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_irq_on;
    (CE_I && irq_flag && irq_allow) |=> IRQ_O;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("allowed flag did not raise interrupt");

  property p_irq_off;
    (CE_I && !irq_allow && !(|(stat & mask))) |=> !IRQ_O;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt raised while not allowed");

  property p_pins_off;
    (CE_I && !iface_on)
      |=> (!SCL_OE_O && !SDA_OE_O && SCL_IN_O && SDA_IN_O);
  endproperty
  a_pins_off: assert property (p_pins_off)
    else $error("disabled interface touches the pins");

  property p_pins_on;
    (CE_I && iface_on && SDA_LOW_I) |=> SDA_OE_O;
  endproperty
  a_pins_on: assert property (p_pins_on)
    else $error("enabled interface does not drive data line");

  property p_ninth;
    (CE_I && ninth) |=> (irq_flag && stat[ICC_ST_NINTH]);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth clock did not set the interrupt flag");

  property p_bank;
    (CE_I && req && !WB_ACK_O && !WB_WE_I && !iface_on
      && word_adr == ICC_ADR_MODE) |=> WB_DAT_O[7:0] == $past(sa_reg);
  endproperty
  a_bank: assert property (p_bank)
    else $error("slave address not visible while disabled");

  property p_mode;
    (CE_I && master_sel && !tx_sel) |=> MODE_O == ICC_MST_RX;
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode decode wrong for master receive");

endmodule
`default_nettype wire

// ---- tb/icc_bus_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Far side of the serial bus: pull-ups and one peer device
// ----------------------------------------------------------------
module icc_bus_peer (
  input wire logic scl_oe_i,
  input wire logic scl_drv_i,
  input wire logic sda_oe_i,
  input wire logic sda_drv_i,
  input wire logic peer_sda_low_i,
  output logic scl_line_o,
  output logic sda_line_o
);
  // A released line rises through its pull-up, so it never keeps the
  // last driven level; any party pulling low wins (wired-and).
  always_comb begin
    scl_line_o = scl_oe_i ? scl_drv_i : 1'b1;
    sda_line_o = (sda_oe_i ? sda_drv_i : 1'b1) & ~peer_sda_low_i;
  end
endmodule
`default_nettype wire

// ---- tb/icc_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module icc_top_tb;
  import icc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic sda_low = 1'b0, frame = 1'b0, busy = 1'b0, arb = 1'b0;
  logic addr_rw = 1'b0, rw_bit = 1'b0, peer_sda = 1'b0;
  logic [31:0] rdat;
  logic ack, irq, scl_o, scl_oe, sda_o, sda_oe, scl_in, sda_in, scl, sda;
  icc_mode_type mode;
  int n_errors = 0;
  int total_checks = 0;
  int lo, hi, n;
  logic [8:0] div_tab [16] = '{9'h01C, 9'h028, 9'h030, 9'h040, 9'h050,
    9'h064, 9'h070, 9'h080, 9'h038, 9'h050, 9'h060, 9'h080, 9'h0A0,
    9'h0C8, 9'h0E0, 9'h100};

  always #2.5 clk = ~clk;

  icc_top uut (
    .CLOCK_I(clk), .RSTN_I(rstn), .CE_I(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_O(scl_oe),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .SCL_IN_O(scl_in), .SDA_IN_O(sda_in), .SDA_LOW_I(sda_low),
    .FRAME_START_I(frame), .SLV_BUSY_I(busy), .ARB_LOST_I(arb),
    .ADDR_RW_I(addr_rw), .RW_BIT_I(rw_bit), .MODE_O(mode)
  );

  icc_bus_peer peer (
    .scl_oe_i(scl_oe), .scl_drv_i(scl_o), .sda_oe_i(sda_oe),
    .sda_drv_i(sda_o), .peer_sda_low_i(peer_sda),
    .scl_line_o(scl), .sda_line_o(sda)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Each access starts one edge later, so the strobe is low at least
  // one cycle between back-to-back accesses.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r & m, e);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic wait_oe(input logic v, output int c);
    c = 0;
    while (scl_oe !== v && c < 2000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 2000) n_errors++;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    rstn <= 1'b1;
    rd(ICC_ADR_CTRL, 32'h0000_0000);
    rd(ICC_ADR_SCTL, 32'h0000_0000);
    rd(ICC_ADR_STAT, 32'h0000_0000);
    chk(mode, ICC_SLV_RX);
    done("reset");
    wr(ICC_ADR_CTRL, 8'h20);
    sda_low <= 1'b1;
    peer_sda <= 1'b1;
    tick(1);
    frame <= 1'b1;
    tick(1);
    frame <= 1'b0;
    tick(6);
    chk(scl_oe, 1'b0);
    chk(sda_oe, 1'b0);
    chk(sda_in, 1'b1);
    wr(ICC_ADR_MODE, 8'hA4);
    wr(ICC_ADR_DATA, 8'h5A);
    wr(ICC_ADR_CTRL, 8'h80);
    tick(3);
    chk(sda_oe, 1'b1);
    chk(sda_in, 1'b0);
    chk(scl_o | sda_o, 1'b0);
    wr(ICC_ADR_MODE, 8'h28);
    rd(ICC_ADR_MODE, 32'h0000_0028);
    wr(ICC_ADR_DATA, 8'h3C);
    rd(ICC_ADR_DATA, 32'h0000_003C);
    wr(ICC_ADR_CTRL, 8'h00);
    rd(ICC_ADR_MODE, 32'h0000_00A4);
    rd(ICC_ADR_DATA, 32'h0000_005A);
    sda_low <= 1'b0;
    peer_sda <= 1'b0;
    done("pins and windows");
    for (int m = 0; m < 4; m++) begin
      wr(ICC_ADR_CTRL, {2'h2, m[1:0], 4'h0});
      tick(3);
      chk(mode, m);
      rd(ICC_ADR_CTRL, {24'h0, 2'h2, m[1:0], 4'h0});
    end
    done("modes");
    for (int i = 0; i < 16; i++) begin
      wr(ICC_ADR_SCTL, {7'h00, i[3]});
      wr(ICC_ADR_MODE, {2'h0, i[2:0], 3'h0});
      wr(ICC_ADR_CTRL, 8'hA0);
      tick(1);
      frame <= 1'b1;
      tick(1);
      frame <= 1'b0;
      wait_oe(1'b1, n);
      wait_oe(1'b0, n);
      wait_oe(1'b1, n);
      wait_oe(1'b0, lo);
      wait_oe(1'b1, hi);
      chk(lo, div_tab[i] / 2);
      chk(lo + hi, div_tab[i]);
      // The third low phase is at least 14 cycles, so this stays in it.
      tick(2);
      chk(scl_in, 1'b0);
      repeat (7) begin
        wait_oe(1'b1, n);
        wait_oe(1'b0, n);
      end
      tick(3);
      chk(irq, 1'b0);
      rd(ICC_ADR_CTRL, 32'h0000_00A2);
      rd(ICC_ADR_STAT, 32'h0000_0001, 32'h0000_0001);
      wr(ICC_ADR_CTRL, 8'hE2);
      tick(3);
      chk(irq, 1'b1);
      wr(ICC_ADR_CTRL, 8'hE0);
      tick(3);
      chk(irq, 1'b0);
      wr(ICC_ADR_MASK, 8'h01);
      tick(3);
      chk(irq, 1'b1);
      wr(ICC_ADR_STAT, 8'h01);
      tick(3);
      chk(irq, 1'b0);
      wr(ICC_ADR_MASK, 8'h00);
      tick(div_tab[i]);
    end
    done("rates and interrupts");
    wr(ICC_ADR_CTRL, 8'hB0);
    tick(1);
    arb <= 1'b1;
    tick(1);
    arb <= 1'b0;
    tick(3);
    chk(mode, ICC_SLV_RX);
    wr(ICC_ADR_CTRL, 8'hB0);
    tick(3);
    chk(mode, ICC_SLV_RX);
    rd(ICC_ADR_CTRL, 32'h0000_0080);
    rd(ICC_ADR_STAT, 32'h0000_0002, 32'h0000_0002);
    rd(ICC_ADR_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(ICC_ADR_CTRL, 8'hB0);
    tick(3);
    chk(mode, ICC_MST_TX);
    done("arbitration");
    // A lost arbitration while the clock enable is low must not act.
    ce <= 1'b0;
    arb <= 1'b1;
    tick(1);
    arb <= 1'b0;
    tick(1);
    ce <= 1'b1;
    tick(3);
    chk(mode, ICC_MST_TX);
    done("clock enable");
    wr(ICC_ADR_CTRL, 8'h80);
    rw_bit <= 1'b1;
    tick(1);
    addr_rw <= 1'b1;
    tick(1);
    addr_rw <= 1'b0;
    tick(3);
    chk(mode, ICC_SLV_TX);
    rd(ICC_ADR_CTRL, 32'h0000_0090);
    wr(ICC_ADR_CTRL, 8'h80);
    busy <= 1'b1;
    wr(ICC_ADR_CTRL, 8'h90);
    tick(5);
    chk(mode, ICC_SLV_RX);
    busy <= 1'b0;
    tick(3);
    chk(mode, ICC_SLV_TX);
    done("slave direction");
    wr(8'h18, 8'hFF);
    rd(8'h18, 32'h0000_0000);
    done("unmapped");
    tally_and_finish();
  end

  // Frames take about 20000 cycles in all; this is twice that.
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
